// file: core/dfrm_defines.svh
// How it works
// - an undervoltage fault clears by itself once the bus voltage is back, without counting as an auto reset.
// - a ground short fault is never cleared by auto or manual reset, only by power-on reset.
// - once the auto reset count reaches the limit, auto resetting stops and the fault action holds.
// - auto resets happen only when auto reset is enabled, at most limit times (0 to 20, default 0).
// - a one-bit setting lets the fault output act during an auto reset wait (1) or keeps it off (0, default).
// - the digital output carries the fault only when its function select holds 8.
// - the auto reset waits the set interval after the alarm (default 1.0 s, 0.1 s to 100.0 s).
// - each decimal digit of an action select gives 0 coast, 1 decelerate, 2 keep running.
// - select a holds input phase loss (ones), output phase loss (tens), load loss (ten thousands), max 20022.
// - select b holds external, comm, memory comm, pid loss from ones upward, max 02222.
// - select c holds run time reached, power-on time reached, user fault from ones upward, max 00222.
// - a stopping fault shows its code, energises the relay and cuts the drive; the motor coasts, or decelerates when its action digit is 1.
// - the alarm lamp flashes while a fault is active.
// - the last three faults are kept with their snapshot for readout.
// - writing 0008 to the command word at 7000H requests a fault reset.
// - a digital input with function 16 requests a fault reset when it becomes active.
`ifndef DFRM_DEFINES_SVH
`define DFRM_DEFINES_SVH
// ***********************************
// register indices, byte address = index * 4
// ***********************************
`define DF_IDX_LIMIT 16'h0D3C
`define DF_IDX_DOUT  16'h0D3D
`define DF_IDX_IVL   16'h0D3E
`define DF_IDX_SELA  16'h0D41
`define DF_IDX_SELB  16'h0D42
`define DF_IDX_SELC  16'h0D43
`define DF_IDX_CTRL  16'h0D50
`define DF_IDX_DOFN  16'h0D51
`define DF_IDX_DIFN  16'h0D52
`define DF_IDX_STAT  16'h0D53
`define DF_IDX_IRQS  16'h0D54
`define DF_IDX_IRQM  16'h0D55
`define DF_IDX_HIST0 16'h0D56
`define DF_IDX_CMD   16'h7000
// ***********************************
// values, limits, reset values
// ***********************************
`define DF_LIMIT_MAX 16'h0014
`define DF_IVL_MIN   16'h0001
`define DF_IVL_MAX   16'h03E8
`define DF_IVL_RST   10'h00A
`define DF_SELA_MAX  16'h4E36
`define DF_SELB_MAX  16'h08AE
`define DF_SELC_MAX  16'h00DE
`define DF_DIGIT_MAX 2
`define DF_CMD_RESET 16'h0008
`define DF_DOFN_FLT  5'h08
`define DF_DIFN_RST  5'h10
`define DF_CODE_UV   16'h0007
`define DF_CODE_GND  16'h0010
`define DF_HIST_N    3
// ***********************************
// timing: interval unit 0.1 s, lamp half period 0.5 s
// ***********************************
`define DF_CLK_NS    50
`define DF_TICK_NS   100000000
`define DF_BLINK_TK  3'h5
`endif

// file: core/dfrm_pkg.sv
package dfrm_pkg;
    typedef enum logic [1:0] {DF_RUN = 2'b00, DF_HALT = 2'b01, DF_WAIT = 2'b10, DF_LOCK = 2'b11} dfrm_state_e;
    typedef enum logic [1:0] {ACT_COAST = 2'b00, ACT_DECEL = 2'b01, ACT_RUN = 2'b10} dfrm_act_e;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [17:0] paddr;
        logic [31:0] pwdata;
    } dfrm_apb_req_s;
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } dfrm_apb_rsp_s;
    typedef struct packed {
        logic        stb;
        logic [3:0]  src;
        logic [15:0] code;
        logic [15:0] info;
    } dfrm_fault_s;
    typedef struct packed {
        logic [15:0] info;
        logic [15:0] code;
    } dfrm_rec_s;
    typedef struct packed {
        dfrm_state_e    state;
        dfrm_act_e      act;
        logic [15:0]    code;
        logic           uv;
        logic [4:0]     cnt;
        logic [31:0]    tick;
        logic [9:0]     wcnt;
        logic [2:0]     bl;
        logic           lamp;
        logic [2:0]     sy1;
        logic [2:0]     sy2;
        logic           di_d;
        logic [4:0]     limit;
        logic           dout;
        logic [9:0]     ivl;
        logic [15:0]    sel_a;
        logic [15:0]    sel_b;
        logic [15:0]    sel_c;
        logic           auto_en;
        logic [4:0]     do_fn;
        logic [4:0]     di_fn;
        logic [3:0]     irq_st;
        logic [3:0]     irq_mk;
        dfrm_rec_s [2:0] hist;
        logic           rdy;
        logic           err;
        logic [31:0]    rdata;
    } dfrm_st_s;
endpackage

// file: core/dfrm_top.sv
`timescale 1ns/1ps
`include "dfrm_defines.svh"
module dfrm_top #(
    parameter int TICK_CYC = `DF_TICK_NS / `DF_CLK_NS
) (
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire dfrm_pkg::dfrm_apb_req_s APB_REQ,
    output      dfrm_pkg::dfrm_apb_rsp_s APB_RSP,
    input  wire dfrm_pkg::dfrm_fault_s  FAULT,
    input  wire logic                   BUS_UV,
    input  wire logic                   GND_SHORT,
    input  wire logic                   DI_PIN,
    output      logic                   RELAY,
    output      logic                   DRIVE_EN,
    output      logic                   DECEL_REQ,
    output      logic                   FAULT_DO,
    output      logic                   ALARM_LAMP,
    output      logic [15:0]            SHOW_CODE,
    output      logic                   IRQ
);
    import dfrm_pkg::*;

    initial begin
        if (TICK_CYC < 1) begin
            $error("TICK_CYC must be at least 1");
        end
    end

    dfrm_st_s s, n;

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic sel_ok(input logic [15:0] v, input logic [15:0] mx);
        int d;
        sel_ok = (v <= mx);
        d = 1;
        for (int k = 0; k < 5; k++) begin
            if ((int'(v) / d) % 10 > `DF_DIGIT_MAX) begin
                sel_ok = 1'b0;
            end
            d = d * 10;
        end
    endfunction

    // unknown sources are treated as hard faults
    function automatic dfrm_act_e act_of(input logic [3:0] src, input dfrm_st_s q);
        logic [15:0] v;
        int          d;
        v = q.sel_a;
        d = 0;
        case (src)
            4'h1: begin v = q.sel_a; d = 1; end
            4'h2: begin v = q.sel_a; d = 10; end
            4'h3: begin v = q.sel_a; d = 10000; end
            4'h4: begin v = q.sel_b; d = 1; end
            4'h5: begin v = q.sel_b; d = 10; end
            4'h6: begin v = q.sel_b; d = 100; end
            4'h7: begin v = q.sel_b; d = 1000; end
            4'h8: begin v = q.sel_c; d = 1; end
            4'h9: begin v = q.sel_c; d = 10; end
            4'hA: begin v = q.sel_c; d = 100; end
            default: begin v = q.sel_a; d = 0; end
        endcase
        if (d == 0) begin
            act_of = ACT_COAST;
        end else begin
            act_of = dfrm_act_e'(2'((int'(v) / d) % 10));
        end
    endfunction

    logic        acc, wr, tk, go_auto, mreset, fault_go;
    logic [15:0] idx;
    logic [31:0] wd;
    logic [3:0]  ev;
    dfrm_act_e   act_n;

    always_comb begin
        n = s;
        ev = 4'h0;
        acc = APB_REQ.psel && APB_REQ.penable;
        idx = APB_REQ.paddr[17:2];
        wd = APB_REQ.pwdata;
        wr = acc && s.rdy && APB_REQ.pwrite && !s.err;
        n.sy1 = {DI_PIN, GND_SHORT, BUS_UV};
        n.sy2 = s.sy1;
        n.di_d = s.sy2[2];
        tk = (s.tick == 32'(TICK_CYC - 1));
        n.tick = tk ? 32'h0 : s.tick + 32'h1;
        if (tk) begin
            n.bl = (s.bl == `DF_BLINK_TK - 3'h1) ? 3'h0 : s.bl + 3'h1;
            n.lamp = (s.bl == `DF_BLINK_TK - 3'h1) ? ~s.lamp : s.lamp;
        end
        // ***********************************
        // apb: one wait state, read data latched in the first access cycle, write data applied in the second
        // ***********************************
        n.rdy = acc && !s.rdy;
        if (acc && !s.rdy) begin
            n.err = 1'b0;
            n.rdata = 32'h0;
            if (APB_REQ.paddr[1:0] != 2'b00) begin
                n.err = 1'b1;
            end else begin
                unique case (idx)
                    `DF_IDX_LIMIT: begin n.rdata = 32'(s.limit); n.err = APB_REQ.pwrite && wd > 32'(`DF_LIMIT_MAX); end
                    `DF_IDX_DOUT:  begin n.rdata = 32'(s.dout); n.err = APB_REQ.pwrite && wd > 32'h1; end
                    `DF_IDX_IVL:   begin
                        n.rdata = 32'(s.ivl);
                        n.err = APB_REQ.pwrite && (wd < 32'(`DF_IVL_MIN) || wd > 32'(`DF_IVL_MAX));
                    end
                    `DF_IDX_SELA:  begin
                        n.rdata = 32'(s.sel_a);
                        n.err = APB_REQ.pwrite && (wd[31:16] != 16'h0 || !sel_ok(wd[15:0], `DF_SELA_MAX));
                    end
                    `DF_IDX_SELB:  begin
                        n.rdata = 32'(s.sel_b);
                        n.err = APB_REQ.pwrite && (wd[31:16] != 16'h0 || !sel_ok(wd[15:0], `DF_SELB_MAX));
                    end
                    `DF_IDX_SELC:  begin
                        n.rdata = 32'(s.sel_c);
                        n.err = APB_REQ.pwrite && (wd[31:16] != 16'h0 || !sel_ok(wd[15:0], `DF_SELC_MAX));
                    end
                    `DF_IDX_CTRL:  n.rdata = 32'(s.auto_en);
                    `DF_IDX_DOFN:  n.rdata = 32'(s.do_fn);
                    `DF_IDX_DIFN:  n.rdata = 32'(s.di_fn);
                    `DF_IDX_STAT:  n.rdata = {s.code, 3'h0, s.cnt, 5'h0, s.uv, s.state};
                    `DF_IDX_IRQS:  n.rdata = 32'(s.irq_st);
                    `DF_IDX_IRQM:  n.rdata = 32'(s.irq_mk);
                    `DF_IDX_CMD:   n.rdata = 32'h0;
                    default: begin
                        if (idx >= `DF_IDX_HIST0 && idx < `DF_IDX_HIST0 + 16'(`DF_HIST_N)) begin
                            n.rdata = s.hist[2'(idx - `DF_IDX_HIST0)];
                            n.err = APB_REQ.pwrite;
                        end else begin
                            n.err = 1'b1;
                        end
                    end
                endcase
            end
        end
        if (wr) begin
            unique case (idx)
                `DF_IDX_LIMIT: n.limit = wd[4:0];
                `DF_IDX_DOUT:  n.dout = wd[0];
                `DF_IDX_IVL:   n.ivl = wd[9:0];
                `DF_IDX_SELA:  n.sel_a = wd[15:0];
                `DF_IDX_SELB:  n.sel_b = wd[15:0];
                `DF_IDX_SELC:  n.sel_c = wd[15:0];
                `DF_IDX_CTRL:  n.auto_en = wd[0];
                `DF_IDX_DOFN:  n.do_fn = wd[4:0];
                `DF_IDX_DIFN:  n.di_fn = wd[4:0];
                `DF_IDX_IRQM:  n.irq_mk = wd[3:0];
                default:       n.limit = s.limit;
            endcase
        end
        // ***********************************
        // fault sequencing
        // ***********************************
        mreset = (wr && idx == `DF_IDX_CMD && wd[15:0] == `DF_CMD_RESET)
               || (s.di_fn == `DF_DIFN_RST && s.sy2[2] && !s.di_d);
        go_auto = s.auto_en && s.cnt < s.limit;
        act_n = act_of(FAULT.src, s);
        fault_go = FAULT.stb && act_n != ACT_RUN;
        unique case (s.state)
            DF_RUN: begin
                if (s.sy2[1]) begin
                    n.state = DF_LOCK;
                    n.act = ACT_COAST;
                    n.code = `DF_CODE_GND;
                    n.hist = {s.hist[1:0], 16'h0, `DF_CODE_GND};
                    ev[0] = 1'b1;
                end else if (s.sy2[0]) begin
                    n.state = DF_HALT;
                    n.uv = 1'b1;
                    n.act = ACT_COAST;
                    n.code = `DF_CODE_UV;
                    n.hist = {s.hist[1:0], 16'h0, `DF_CODE_UV};
                    ev[0] = 1'b1;
                end else if (FAULT.stb) begin
                    n.hist = {s.hist[1:0], FAULT.info, FAULT.code};
                    if (fault_go) begin
                        n.act = act_n;
                        n.code = FAULT.code;
                        ev[0] = 1'b1;
                        n.state = go_auto ? DF_WAIT : DF_HALT;
                        ev[2] = s.auto_en && !go_auto;
                        n.wcnt = 10'h0;
                        n.tick = 32'h0;
                    end
                end
            end
            DF_HALT, DF_WAIT: begin
                if (s.sy2[1]) begin
                    n.state = DF_LOCK;
                    n.act = ACT_COAST;
                    n.code = `DF_CODE_GND;
                    n.uv = 1'b0;
                    n.hist = {s.hist[1:0], 16'h0, `DF_CODE_GND};
                    ev[0] = 1'b1;
                end else if (s.uv) begin
                    if (!s.sy2[0]) begin
                        n.state = DF_RUN;
                        n.uv = 1'b0;
                        ev[3] = 1'b1;
                    end
                end else if (mreset) begin
                    n.state = DF_RUN;
                    n.cnt = 5'h0;
                end else if (s.state == DF_WAIT && tk) begin
                    n.wcnt = s.wcnt + 10'h1;
                    if (s.wcnt == s.ivl - 10'h1) begin
                        n.state = DF_RUN;
                        n.cnt = s.cnt + 5'h1;
                        ev[1] = 1'b1;
                    end
                end
            end
            DF_LOCK: n.state = DF_LOCK;
        endcase
        n.irq_st = (s.irq_st & ~((wr && idx == `DF_IDX_IRQS) ? wd[3:0] : 4'h0)) | ev;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s <= '{state: DF_RUN, act: ACT_COAST, ivl: `DF_IVL_RST, default: '0};
        end else begin
            s <= n;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign APB_RSP.pready  = s.rdy;
    assign APB_RSP.prdata  = s.rdata;
    assign APB_RSP.pslverr = s.err;
    assign RELAY      = s.state != DF_RUN;
    assign DRIVE_EN   = s.state == DF_RUN;
    assign DECEL_REQ  = s.state != DF_RUN && s.act == ACT_DECEL;
    assign FAULT_DO   = s.state != DF_RUN && s.do_fn == `DF_DOFN_FLT
                        && (s.state != DF_WAIT || s.dout);
    assign ALARM_LAMP = s.state != DF_RUN && s.lamp;
    assign SHOW_CODE  = s.code;
    assign IRQ        = |(s.irq_st & s.irq_mk);

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_lock; s.state == DF_LOCK |=> s.state == DF_LOCK; endproperty
    a_lock: assert property (p_lock) else $error("ground short lock left");
    property p_uv; s.uv && s.state != DF_LOCK && !s.sy2[0] && !s.sy2[1] |=> s.state == DF_RUN && s.cnt == $past(s.cnt);
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not self cleared");
    property p_lim; s.state == DF_RUN && !s.sy2[1] && !s.sy2[0] && fault_go && s.cnt >= s.limit |=> s.state == DF_HALT;
    endproperty
    a_lim: assert property (p_lim) else $error("auto reset beyond limit");
    property p_wait; s.state == DF_WAIT |-> s.auto_en && s.cnt < s.limit; endproperty
    a_wait: assert property (p_wait) else $error("wait without allowance");
    property p_dout; s.state == DF_WAIT && !s.dout |-> !FAULT_DO; endproperty
    a_dout: assert property (p_dout) else $error("fault output during auto reset");
    property p_dofn; FAULT_DO |-> s.do_fn == `DF_DOFN_FLT && RELAY; endproperty
    a_dofn: assert property (p_dofn) else $error("fault output with wrong function");
    property p_ivl; s.state == DF_WAIT && $past(s.state) == DF_RUN |-> s.wcnt == 10'h0 && s.tick == 32'h0;
    endproperty
    a_ivl: assert property (p_ivl) else $error("wait interval not restarted");
    property p_stop; s.state != DF_RUN |-> RELAY && !DRIVE_EN && SHOW_CODE == s.code; endproperty
    a_stop: assert property (p_stop) else $error("stop outputs wrong");
    property p_lamp; ALARM_LAMP |-> s.state != DF_RUN; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp lit without fault");
    property p_cmd; s.state == DF_HALT && !s.uv && !s.sy2[1] && wr && idx == `DF_IDX_CMD && wd[15:0] == `DF_CMD_RESET
        |=> s.state == DF_RUN && s.cnt == 5'h0;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command reset ignored");
endmodule

// file: test/dfrm_stage_model.sv
`timescale 1ns/1ps
module dfrm_stage_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       uv_req,
    input  wire logic       gnd_req,
    input  wire logic       drive_en,
    input  wire logic       decel_req,
    input  wire logic       alarm_lamp,
    output      logic       bus_uv,
    output      logic       gnd_short,
    output      int         lamp_flips,
    output      logic [7:0] speed
);
    // ****************************************
    // power stage, bus comparator, lamp watch
    // ****************************************
    logic lamp_q;
    // sensor levels lag their cause by a cycle, like a real comparator
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_uv     <= 1'b0;
            gnd_short  <= 1'b0;
            lamp_q     <= 1'b0;
            lamp_flips <= 0;
            speed      <= 8'h00;
        end else begin
            bus_uv     <= uv_req;
            gnd_short  <= gnd_req;
            lamp_q     <= alarm_lamp;
            if (lamp_q != alarm_lamp) lamp_flips <= lamp_flips + 1;
            if (drive_en && speed != 8'hFF) speed <= speed + 8'h01;
            else if (!drive_en && decel_req && speed > 8'h01) speed <= speed - 8'h02;
            else if (!drive_en && !decel_req && speed != 8'h00) speed <= speed - 8'h01;
        end
    end
endmodule

// file: test/dfrm_tb.sv
`timescale 1ns/1ps
`include "dfrm_defines.svh"
module tb;
    import dfrm_pkg::*;
    // ****************************************
    // signals and case tables
    // ****************************************
    typedef struct packed {logic w; logic [15:0] i; logic [31:0] d; logic e; logic [31:0] r;} dfrm_reg_row_s;
    typedef struct packed {logic [15:0] i; logic [15:0] s; logic [3:0] src; logic rl; logic dc;} dfrm_act_row_s;
    logic          clk;
    logic          nrst;
    dfrm_apb_req_s req;
    dfrm_apb_rsp_s rsp;
    dfrm_fault_s   flt;
    logic          uv_req, gnd_req, di, bus_uv, gnd_short, relay, drive_en, decel_req, fault_do, alarm_lamp, irq;
    logic [15:0]   show_code;
    logic [7:0]    speed;
    logic [31:0]   rdat;
    logic          rerr;
    int            n_fail, check_count, lamp_flips, n, f0;
    dfrm_reg_row_s regs[$] = '{
        '{0, `DF_IDX_LIMIT, 0, 0, 0}, '{0, `DF_IDX_DOUT, 0, 0, 0}, '{0, `DF_IDX_IVL, 0, 0, 32'hA},
        '{0, `DF_IDX_SELA, 0, 0, 0}, '{0, `DF_IDX_SELB, 0, 0, 0}, '{0, `DF_IDX_SELC, 0, 0, 0},
        '{1, `DF_IDX_LIMIT, 32'h14, 0, 32'h14}, '{1, `DF_IDX_LIMIT, 32'h15, 1, 32'h14},
        '{1, `DF_IDX_DOUT, 32'h2, 1, 0}, '{1, `DF_IDX_DOUT, 32'h1, 0, 32'h1},
        '{1, `DF_IDX_IVL, 32'h0, 1, 32'hA}, '{1, `DF_IDX_IVL, 32'h3E9, 1, 32'hA},
        '{1, `DF_IDX_IVL, 32'h3E8, 0, 32'h3E8}, '{1, `DF_IDX_SELA, 32'h4E37, 1, 0},
        '{1, `DF_IDX_SELA, 32'h4E36, 0, 32'h4E36}, '{1, `DF_IDX_SELA, 32'h3, 1, 32'h4E36},
        '{1, `DF_IDX_SELA, 32'h10000, 1, 32'h4E36}, '{1, `DF_IDX_SELB, 32'h2FBE, 1, 0},
        '{1, `DF_IDX_SELB, 32'h8AE, 0, 32'h8AE}, '{1, `DF_IDX_SELC, 32'h4C6, 1, 0},
        '{1, `DF_IDX_SELC, 32'hDE, 0, 32'hDE}, '{1, `DF_IDX_HIST0, 32'h1, 1, 0}, '{1, 16'h0D60, 32'h1, 1, 0}};
    dfrm_act_row_s acts[$] = '{
        '{`DF_IDX_SELA, 16'h1, 1, 1, 1}, '{`DF_IDX_SELA, 16'hA, 2, 1, 1}, '{`DF_IDX_SELA, 16'h4E20, 3, 0, 0},
        '{`DF_IDX_SELA, 16'h2710, 3, 1, 1}, '{`DF_IDX_SELB, 16'h2, 4, 0, 0}, '{`DF_IDX_SELB, 16'hA, 5, 1, 1},
        '{`DF_IDX_SELB, 16'h64, 6, 1, 1}, '{`DF_IDX_SELB, 16'h7D0, 7, 0, 0}, '{`DF_IDX_SELC, 16'h1, 8, 1, 1},
        '{`DF_IDX_SELC, 16'h14, 9, 0, 0}, '{`DF_IDX_SELC, 16'h64, 10, 1, 1}, '{`DF_IDX_SELB, 16'h0, 4, 1, 0},
        '{`DF_IDX_SELA, 16'h0, 12, 1, 0}};
    dfrm_top #(.TICK_CYC(4)) DUT (.CLK(clk), .NRST(nrst), .APB_REQ(req), .APB_RSP(rsp), .FAULT(flt),
        .BUS_UV(bus_uv), .GND_SHORT(gnd_short), .DI_PIN(di), .RELAY(relay), .DRIVE_EN(drive_en),
        .DECEL_REQ(decel_req), .FAULT_DO(fault_do), .ALARM_LAMP(alarm_lamp), .SHOW_CODE(show_code), .IRQ(irq));
    dfrm_stage_model STAGE (.clk(clk), .nrst(nrst), .uv_req(uv_req), .gnd_req(gnd_req), .drive_en(drive_en),
        .decel_req(decel_req), .alarm_lamp(alarm_lamp), .bus_uv(bus_uv), .gnd_short(gnd_short),
        .lamp_flips(lamp_flips), .speed(speed));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    // pready looked at mid-cycle, where it is settled; the request is released only after the edge that takes it
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(negedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        chk("pready_wait", 1, {31'h0, k < 20});
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        @(posedge clk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask
    task automatic rdc(input string nm, input logic [15:0] i, input logic [31:0] e);
        apb(1'b0, {i, 2'b00}, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic st_chk(input logic [1:0] s, input logic [4:0] c);
        apb(1'b0, {`DF_IDX_STAT, 2'b00}, 32'h0);
        chk("state", {30'h0, s}, {30'h0, rdat[1:0]});
        chk("count", {27'h0, c}, {27'h0, rdat[12:8]});
    endtask
    task automatic fault(input logic [3:0] s, input logic [15:0] c, input logic [15:0] inf);
        flt <= '{1'b1, s, c, inf};
        @(posedge clk);
        flt.stb <= 1'b0;
        cyc(2);
    endtask
    task automatic di_pulse;
        di <= 1'b1;
        cyc(4);
        di <= 1'b0;
        cyc(4);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        req = '0;
        flt = '0;
        uv_req = 1'b0;
        gnd_req = 1'b0;
        di = 1'b0;
        cyc(3);
        nrst <= 1'b1;
        cyc(1);
        chk("drive_en_rst", 1, drive_en);
        foreach (regs[i]) begin
            if (regs[i].w) wr(regs[i].i, regs[i].d);
            if (regs[i].w) chk("slverr", regs[i].e, rerr);
            rdc("readback", regs[i].i, regs[i].r);
        end
        apb(1'b1, {`DF_IDX_LIMIT, 2'b00} + 18'h1, 32'h5);
        chk("misalign_err", 1, rerr);
        wr(`DF_IDX_DOFN, 32'h8);
        foreach (acts[i]) begin
            wr(acts[i].i, {16'h0, acts[i].s});
            fault(acts[i].src, 16'h0100 + 16'(i), 16'h0A00 + 16'(i));
            chk("relay", acts[i].rl, relay);
            chk("decel", acts[i].dc, decel_req);
            chk("fault_do", acts[i].rl, fault_do);
            if (!acts[i].dc) chk("drive_en", !acts[i].rl, drive_en);
            if (acts[i].rl) chk("code", 16'h0100 + 16'(i), show_code);
            wr(`DF_IDX_CMD, `DF_CMD_RESET);
            chk("relay_clr", 0, relay);
        end
        n = acts.size();
        for (int j = 0; j < 3; j++) rdc("hist", `DF_IDX_HIST0 + 16'(j), {16'h0A00 + 16'(n-1-j), 16'h0100 + 16'(n-1-j)});
        wr(`DF_IDX_DOFN, 32'h0);
        fault(1, 16'h0001, 16'h0);
        chk("fault_do_off", 0, fault_do);
        di_pulse();
        chk("di_unassigned", 1, relay);
        wr(`DF_IDX_DIFN, 32'h10);
        di_pulse();
        chk("di_reset", 0, relay);
        wr(`DF_IDX_CTRL, 32'h1);
        wr(`DF_IDX_LIMIT, 32'h1);
        wr(`DF_IDX_DOUT, 32'h0);
        wr(`DF_IDX_IVL, 32'h2);
        wr(`DF_IDX_DOFN, 32'h8);
        wr(`DF_IDX_IRQS, 32'hF);
        fault(1, 16'h0001, 16'h0);
        chk("do_in_wait", 0, fault_do);
        n = 0;
        while (relay !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("wait_window", 1, {31'h0, n >= 5 && n <= 10});
        st_chk(2'd0, 5'd1);
        fault(1, 16'h0001, 16'h0);
        cyc(20);
        st_chk(2'd1, 5'd1);
        chk("do_halt", 1, fault_do);
        rdc("irqs", `DF_IDX_IRQS, 32'h7);
        chk("irq_masked", 0, irq);
        wr(`DF_IDX_IRQM, 32'h4);
        chk("irq_on", 1, irq);
        wr(`DF_IDX_IRQS, 32'h4);
        chk("irq_clr", 0, irq);
        wr(`DF_IDX_CMD, `DF_CMD_RESET);
        wr(`DF_IDX_LIMIT, 32'h0);
        fault(1, 16'h0001, 16'h0);
        st_chk(2'd1, 5'd0);
        wr(`DF_IDX_CMD, `DF_CMD_RESET);
        wr(`DF_IDX_LIMIT, 32'h1);
        wr(`DF_IDX_DOUT, 32'h1);
        fault(1, 16'h0001, 16'h0);
        chk("do_in_wait", 1, fault_do);
        cyc(12);
        wr(`DF_IDX_LIMIT, 32'h14);
        uv_req <= 1'b1;
        cyc(5);
        chk("uv_code", `DF_CODE_UV, show_code);
        st_chk(2'd1, 5'd1);
        f0 = lamp_flips;
        cyc(50);
        chk("lamp", 1, {31'h0, lamp_flips - f0 >= 2});
        uv_req <= 1'b0;
        cyc(5);
        st_chk(2'd0, 5'd1);
        chk("lamp_off", 0, alarm_lamp);
        apb(1'b0, {`DF_IDX_IRQS, 2'b00}, 32'h0);
        chk("uv_irq", 1, rdat[3]);
        gnd_req <= 1'b1;
        cyc(5);
        gnd_req <= 1'b0;
        wr(`DF_IDX_CMD, `DF_CMD_RESET);
        di_pulse();
        cyc(20);
        chk("gnd_code", `DF_CODE_GND, show_code);
        st_chk(2'd3, 5'd1);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(2);
        chk("relay_pwr", 0, relay);
        chk("code_pwr", 0, show_code);
        end_sim();
    end
endmodule
